// File: design/channel_fail_count_config.sv
// Per-channel fail counter with static force and dynamic control registers
`timescale 1ns/1ns
`default_nettype none

module channel_fail_count_config
	import fail_count_pkg::*;
#(
	parameter int unsigned CHANNEL = 0
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	input  wire logic                          clk_en,
	input  wire logic [fail_count_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [fail_count_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [fail_count_pkg::DATA_W-1:0] reg_rdata,
	output logic                               reg_rvalid,
	input  wire logic                          pattern_run,
	input  wire logic                          pattern_data,
	input  wire logic                          pattern_enable,
	input  wire logic                          primary_period_clock,
	input  wire logic                          alternate_cycle_clock,
	input  wire logic [fail_count_pkg::HITS_W-1:0] fail_hits,
	input  wire logic [fail_count_pkg::HITS_W-1:0] pattern_fail_mask,
	input  wire logic                          low_jitter_clk,
	output logic                               drive_data_out,
	output logic                               drive_enable_out,
	output logic                               edge_gen_enable,
	output logic                               cycle_clock_select,
	output logic      [fail_count_pkg::HITS_W-1:0] accum_fail
);
	import fail_count_pkg::*;

	typedef struct packed {
		logic [COUNT_W-1:0] count;
		logic [COUNT_W-1:0] snap;
		logic [DATA_W-1:0]  preload_low;
		logic [STAT_W-1:0]  force_bits;
		logic               edge_en;
		logic               alt_sel;
		logic               fail_mask;
		logic               ljc_en;
		logic               inc_pulse;
		logic [DATA_W-1:0]  rdata;
		logic               rvalid;
		logic               drive_data;
		logic               drive_en;
		logic [HITS_W-1:0]  accum;
		logic               run_seen;
		logic               ljc_s1;
		logic               ljc_s2;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Low jitter clock routing only exists on two channels
	localparam logic LJC_PRESENT = (CHANNEL == LJC_CHAN_A) || (CHANNEL == LJC_CHAN_B);

	// Number of set bits in a group of fail hits
	function automatic logic [2:0] hit_count(input logic [HITS_W-1:0] hits);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < HITS_W; i++) begin
			n = n + {2'h0, hits[i]};
		end
		return n;
	endfunction

	// Access decode
	logic               wr_low;
	logic               wr_high;
	logic               wr_stat;
	logic               wr_dyn;
	logic               rd_low;
	logic               rd_high;
	logic               period_tick;
	logic [HITS_W-1:0]  live_fails;
	logic [COUNT_W-1:0] count_add;

	assign wr_low  = reg_wr && (reg_addr == OFS_COUNT_LOW);
	assign wr_high = reg_wr && (reg_addr == OFS_COUNT_HIGH);
	assign wr_stat = reg_wr && (reg_addr == OFS_STATIC);
	assign wr_dyn  = reg_wr && (reg_addr == OFS_DYNAMIC);
	assign rd_low  = reg_rd && (reg_addr == OFS_COUNT_LOW);
	assign rd_high = reg_rd && (reg_addr == OFS_COUNT_HIGH);

	// Fails are sampled once per selected pattern period
	assign period_tick = s_q.alt_sel ? alternate_cycle_clock : primary_period_clock;
	// Alternate clock mode turns every compare into no action, so no fails land
	assign live_fails  = (period_tick && !s_q.alt_sel && !s_q.fail_mask) ?
		(fail_hits & ~pattern_fail_mask) : '0;
	// Up to four fails per period plus the software increment pulse
	assign count_add   = {29'h0, hit_count(live_fails)} + {31'h0, s_q.inc_pulse};

	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.rvalid    = 1'b0;
		s_d.inc_pulse = 1'b0;
		s_d.ljc_s1    = low_jitter_clk;
		s_d.ljc_s2    = s_q.ljc_s1;
		s_d.run_seen  = pattern_run;

		// Counting keeps going during reads; modulo add gives the wrap
		s_d.count = s_q.count + count_add;
		// A high write is the only load path; a fail in the same cycle is lost
		if (wr_high) begin
			s_d.count = {reg_wdata, s_q.preload_low};
		end
		if (wr_low) begin
			s_d.preload_low = reg_wdata;
		end
		if (wr_stat) begin
			s_d.force_bits = reg_wdata[STAT_W-1:0];
		end
		if (wr_dyn) begin
			s_d.edge_en   = reg_wdata[DYN_EDGE_EN];
			s_d.alt_sel   = reg_wdata[DYN_ALT_SEL];
			s_d.fail_mask = reg_wdata[DYN_FAIL_MASK];
			s_d.ljc_en    = reg_wdata[DYN_LJC_EN];
			s_d.inc_pulse = reg_wdata[DYN_INC];
		end

		// Accumulated fail bits restart at each burst start, set wins otherwise
		if (pattern_run && !s_q.run_seen) begin
			s_d.accum = live_fails;
		end else begin
			s_d.accum = s_q.accum | live_fails;
		end

		// Read data, one cycle after the strobe
		if (reg_rd) begin
			s_d.rvalid = 1'b1;
			unique case (reg_addr)
				OFS_COUNT_LOW: begin
					s_d.rdata = s_q.count[DATA_W-1:0];
					s_d.snap  = s_q.count;
				end
				OFS_COUNT_HIGH: s_d.rdata = s_q.snap[COUNT_W-1:DATA_W];
				OFS_STATIC:     s_d.rdata = {12'h000, s_q.force_bits};
				OFS_DYNAMIC:    s_d.rdata = {11'h000, s_q.edge_en, s_q.alt_sel, s_q.fail_mask, s_q.ljc_en, 1'b0};
				default:        s_d.rdata = HALF_RST;
			endcase
		end

		// Drive data: low jitter clock, then burst pattern, then static forces
		if (LJC_PRESENT && s_q.ljc_en) begin
			s_d.drive_data = s_q.ljc_s2;
		end else if (pattern_run) begin
			s_d.drive_data = pattern_data;
		end else if (!s_q.edge_en) begin
			// Both data forces together is the host's fault; low wins here
			if (s_q.force_bits[STAT_DATA_LOW]) begin
				s_d.drive_data = 1'b0;
			end else if (s_q.force_bits[STAT_DATA_HIGH]) begin
				s_d.drive_data = 1'b1;
			end
		end
		// Clock routing only touches data, so the enable forces still apply under it
		if (pattern_run) begin
			s_d.drive_en = pattern_enable;
		end else if (!s_q.edge_en) begin
			// Both enable forces together is the host's fault; off wins here
			if (s_q.force_bits[STAT_DRV_OFF]) begin
				s_d.drive_en = 1'b0;
			end else if (s_q.force_bits[STAT_DRV_ON]) begin
				s_d.drive_en = 1'b1;
			end
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign reg_rdata          = s_q.rdata;
	assign reg_rvalid         = s_q.rvalid;
	assign drive_data_out     = s_q.drive_data;
	assign drive_enable_out   = s_q.drive_en;
	assign edge_gen_enable    = s_q.edge_en;
	assign cycle_clock_select = s_q.alt_sel;
	assign accum_fail         = s_q.accum;

	// Checks
	sequence low_read_s;
		clk_en && rd_low;
	endsequence

	sequence high_read_s;
		clk_en && rd_high;
	endsequence

	sequence inc_write_s;
		clk_en && wr_dyn && reg_wdata[DYN_INC];
	endsequence

	sequence dyn_write_s;
		clk_en && wr_dyn;
	endsequence

	count_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !wr_high |=> s_q.count == $past(s_q.count) + $past(count_add))
		else $error("fail counter did not advance by the fail count");

	low_snapshot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		low_read_s |=> s_q.snap == $past(s_q.count) && reg_rvalid)
		else $error("low read did not snapshot the counter");

	high_from_snap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		low_read_s ##1 (!clk_en || !rd_low)[*1] ##1 high_read_s
		|=> reg_rdata == $past(s_q.snap[COUNT_W-1:DATA_W], 1))
		else $error("high read not taken from snapshot");

	preload_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && wr_low ##1 (!wr_low)[*1] ##1 clk_en && wr_high
		|=> s_q.count == {$past(reg_wdata), $past(reg_wdata, 3)})
		else $error("preload did not load the full count");

	force_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !pattern_run && !s_q.edge_en && !s_q.ljc_en && s_q.force_bits[STAT_DATA_LOW]
		|=> !drive_data_out)
		else $error("drive data not forced low");

	force_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !pattern_run && !s_q.edge_en && !s_q.ljc_en && s_q.force_bits[STAT_DATA_HIGH]
		&& !s_q.force_bits[STAT_DATA_LOW] |=> drive_data_out)
		else $error("drive data not forced high");

	driver_force_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !pattern_run && !s_q.edge_en && !s_q.ljc_en && (s_q.force_bits[STAT_DRV_OFF] ||
		s_q.force_bits[STAT_DRV_ON]) |=> drive_enable_out == !$past(s_q.force_bits[STAT_DRV_OFF]))
		else $error("drive enable force not applied");

	pattern_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && pattern_run && !s_q.ljc_en |=> drive_data_out == $past(pattern_data)
		&& drive_enable_out == $past(pattern_enable))
		else $error("drive outputs not following pattern");

	mask_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(s_q.fail_mask || s_q.alt_sel) && !s_q.inc_pulse && !wr_high && clk_en |=> $stable(s_q.count))
		else $error("blocked fails reached the counter");

	inc_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		inc_write_s ##1 (clk_en && !wr_high && live_fails == '0) |=> s_q.count == $past(s_q.count) + 32'h1)
		else $error("increment write did not add one");

	low_read_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		low_read_s |=> reg_rdata == $past(s_q.count[DATA_W-1:0]))
		else $error("low read did not return the live low half");

	high_write_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && wr_high |=> s_q.count == {$past(reg_wdata), $past(s_q.preload_low)})
		else $error("high write did not load held low half");

	count_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !period_tick && !s_q.inc_pulse && !wr_high |=> $stable(s_q.count))
		else $error("counter moved without a period strobe");

	edge_enable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		dyn_write_s |=> edge_gen_enable == $past(reg_wdata[DYN_EDGE_EN]))
		else $error("edge enable did not follow the write");

	clock_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		dyn_write_s |=> cycle_clock_select == $past(reg_wdata[DYN_ALT_SEL]))
		else $error("cycle clock choice did not follow the write");

	mask_accum_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && s_q.fail_mask && !(pattern_run && !s_q.run_seen) |=> $stable(accum_fail))
		else $error("masked fails reached the sticky bits");

	ljc_route_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && LJC_PRESENT && s_q.ljc_en |=> drive_data_out == $past(s_q.ljc_s2))
		else $error("low jitter clock not routed to drive data");
endmodule

`default_nettype wire

// File: design/fail_count_pkg.sv
// Constants shared by the channel fail counter and configuration block
package fail_count_pkg;
	localparam int unsigned ADDR_W          = 5;
	localparam int unsigned DATA_W          = 16;
	localparam int unsigned COUNT_W         = 32;
	localparam int unsigned HITS_W          = 4;
	// Register offsets
	localparam logic [4:0]  OFS_COUNT_LOW   = 5'h01;
	localparam logic [4:0]  OFS_COUNT_HIGH  = 5'h02;
	localparam logic [4:0]  OFS_STATIC      = 5'h03;
	localparam logic [4:0]  OFS_DYNAMIC     = 5'h04;
	// Static force field positions
	localparam int unsigned STAT_DRV_ON     = 0;
	localparam int unsigned STAT_DRV_OFF    = 1;
	localparam int unsigned STAT_DATA_HIGH  = 2;
	localparam int unsigned STAT_DATA_LOW   = 3;
	localparam int unsigned STAT_W          = 4;
	// Dynamic control field positions
	localparam int unsigned DYN_INC         = 0;
	localparam int unsigned DYN_LJC_EN      = 1;
	localparam int unsigned DYN_FAIL_MASK   = 2;
	localparam int unsigned DYN_ALT_SEL     = 3;
	localparam int unsigned DYN_EDGE_EN     = 4;
	// Reset values
	localparam logic [31:0] COUNT_RST       = 32'h0000_0000;
	localparam logic [15:0] HALF_RST        = 16'h0000;
	localparam logic [3:0]  STAT_RST        = 4'h0;
	localparam logic        DYN_BIT_RST     = 1'b0;
	// Channels that carry the low jitter clock
	localparam int unsigned LJC_CHAN_A      = 2;
	localparam int unsigned LJC_CHAN_B      = 3;
endpackage

// File: tb/host_cpu_model.sv
// Host CPU model on the register strobe bus
`timescale 1ns/1ns
`default_nettype none
module host_cpu_model
	import fail_count_pkg::*;
(
	input  wire logic                         core_clk,
	output logic [fail_count_pkg::ADDR_W-1:0] reg_addr,
	output logic [fail_count_pkg::DATA_W-1:0] reg_wdata,
	output logic                              reg_wr,
	output logic                              reg_rd
);
	// Strobes idle low from time zero
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle strobe, entered and left just after an edge
	task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;  // Idle lines never keep the last value
		reg_wdata = ~d;
		// One idle edge, so a following request never re-raises a strobe in this time step
		@(posedge core_clk);
		#1;
	endtask
	// Preload, only while no pattern runs: low to holding, high loads all
	task automatic count_write(input logic [31:0] v);
		xfer(1'b1, OFS_COUNT_LOW, v[15:0]);
		xfer(1'b1, OFS_COUNT_HIGH, v[31:16]);
	endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the channel fail counter block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import fail_count_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, reg_rvalid, ddo, deo, ege, ccs;
	logic        run = 1'b0, pdat = 1'b0, pen = 1'b0, pclk = 1'b0, ljc = 1'b0, ce = 1'b1;
	logic [3:0]  hits = 4'hf, fmask = 4'h0, accum;
	logic [15:0] expq[$];
	logic [31:0] r;
	// Never both of a pair set at once
	logic [3:0]  stat_tab[4] = '{4'h4, 4'h8, 4'h1, 4'h2};
	logic        exp_d[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
	logic        exp_e[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
	int          fail_count = 0;
	int          checks = 0;
	// 50 MHz core clock
	always #10 core_clk = ~core_clk;
	channel_fail_count_config #(.CHANNEL(2)) uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pattern_run(run), .pattern_data(pdat),
		.pattern_enable(pen), .primary_period_clock(pclk), .alternate_cycle_clock(pclk),
		.fail_hits(hits), .pattern_fail_mask(fmask), .low_jitter_clk(ljc), .drive_data_out(ddo),
		.drive_enable_out(deo), .edge_gen_enable(ege), .cycle_clock_select(ccs), .accum_fail(accum));
	host_cpu_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Reads note their expected data before the strobe goes out
	task automatic rx(input logic [4:0] a, input logic [15:0] e);
		expq.push_back(e);
		host.xfer(1'b0, a, 16'h0000);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		host.xfer(1'b1, a, d);
	endtask
	// Both period strobes fire together; only the primary one counts, and only while it is selected
	task automatic strobe(input logic [3:0] m);
		fmask = m;
		pclk = 1'b1;
		step(1);
		pclk = 1'b0;
		step(1);
	endtask
	task automatic done(input string n);
		$display("test %s done", n);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Read data is looked at mid-cycle, once it has settled
	always @(negedge core_clk) begin
		if (reg_rvalid === 1'b1) begin
			if (expq.size() == 0)
				chk("unexpected rvalid", 32'h0, 32'h1);
			else
				chk("reg_rdata", expq.pop_front(), reg_rdata);
		end
	end
	// Watchdog well beyond the roughly 150 cycles the tests need
	initial begin
		#100000;
		fail_count++;
		summarize();
	end
	initial begin
		void'($urandom(32'h46d0));
		step(20);
		rst_n = 1'b1;
		// Reset values, then an unmapped place
		for (int a = 1; a <= 4; a++)
			rx(a[4:0], 16'h0000);
		rx(5'h1f, 16'h0000);
		done("reset");
		// Random preload read back low then high
		r = $urandom;
		host.count_write(r);
		rx(OFS_COUNT_LOW, r[15:0]);
		rx(OFS_COUNT_HIGH, r[31:16]);
		// All ones plus the software pulse wraps to zero; a zero write adds nothing
		host.count_write(32'hffff_ffff);
		wr(OFS_DYNAMIC, 16'h0001);
		wr(OFS_DYNAMIC, 16'h0000);
		step(2);
		rx(OFS_COUNT_LOW, 16'h0000);
		rx(OFS_COUNT_HIGH, 16'h0000);
		done("preload");
		// Hits with masks, the fail mask bit and the alternate clock
		host.count_write(32'h0000_fff8);
		strobe(4'h0);
		strobe(4'h3);
		wr(OFS_DYNAMIC, 16'h0004);
		strobe(4'h0);
		wr(OFS_DYNAMIC, 16'h0008);
		strobe(4'h0);
		wr(OFS_DYNAMIC, 16'h0000);
		rx(OFS_COUNT_LOW, 16'hfffe);
		strobe(4'h0);
		rx(OFS_COUNT_HIGH, 16'h0000);
		rx(OFS_COUNT_LOW, 16'h0002);
		rx(OFS_COUNT_HIGH, 16'h0001);
		done("count");
		// Static forces in an order that moves each output
		foreach (stat_tab[i]) begin
			wr(OFS_STATIC, {12'h000, stat_tab[i]});
			step(2);
			chk("drive_data_out", exp_d[i], ddo);
			chk("drive_enable_out", exp_e[i], deo);
		end
		// A running pattern overrides the forces
		wr(OFS_STATIC, 16'h000a);
		rx(OFS_STATIC, 16'h000a);
		pdat = 1'b1;
		pen = 1'b1;
		run = 1'b1;
		step(2);
		chk("drive_data_out", 1'b1, ddo);
		chk("drive_enable_out", 1'b1, deo);
		// Sticky bits restart at burst start, then keep only unmasked hits
		chk("accum_fail", 4'h0, accum);
		strobe(4'h5);
		chk("accum_fail", 4'ha, accum);
		run = 1'b0;
		step(2);
		chk("drive_data_out", 1'b0, ddo);
		chk("drive_enable_out", 1'b0, deo);
		// Edge enable and clock choice: both set, random, both clear
		for (int i = 0; i < 3; i++) begin
			r = (i == 0) ? 32'h18 : (i == 1) ? ($urandom & 32'h18) : 32'h0;
			wr(OFS_DYNAMIC, r[15:0]);
			rx(OFS_DYNAMIC, r[15:0]);
			step(2);
			chk("edge_gen_enable", r[4], ege);
			chk("cycle_clock_select", r[3], ccs);
		end
		// Low jitter clock beats the force low on this channel
		wr(OFS_DYNAMIC, 16'h0002);
		ljc = 1'b1;
		step(5);
		chk("drive_data_out", 1'b1, ddo);
		ljc = 1'b0;
		step(5);
		chk("drive_data_out", 1'b0, ddo);
		// Clock enable low freezes all state: the write is lost and the clock routing waits
		ce = 1'b0;
		ljc = 1'b1;
		step(5);
		chk("drive_data_out", 1'b0, ddo);
		wr(OFS_STATIC, 16'h0005);
		ce = 1'b1;
		rx(OFS_STATIC, 16'h000a);
		step(2);
		chk("drive_data_out", 1'b1, ddo);
		done("outputs");
		summarize();
	end
endmodule
`default_nettype wire
